// ### core/lbs_clk_div.sv
// Divider making the half-period ticks of the processor clock output.
// Assumes synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "lbs_map.svh"
module lbs_clk_div
#(
	parameter int HALF_CYCLES = `LBS_HALF_CYCLES
)
(
	input  wire logic   mclk,
	input  wire logic   rst,
	lbs_tick_if.src     dv
);
	logic [15:0] count;
	logic        phase;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			count <= 16'h0000;
			phase <= 1'b0;
			dv.tick <= 1'b0;
			dv.rise <= 1'b0;
		end
		else if (count == 16'(HALF_CYCLES - 1))
		begin
			count <= 16'h0000;
			phase <= ~phase;
			dv.tick <= 1'b1;
			dv.rise <= ~phase;
		end
		else
		begin
			count <= count + 16'h0001;
			dv.tick <= 1'b0;
		end
	end
endmodule : lbs_clk_div
`default_nettype wire

// ### core/lbs_map.svh
// Timing figures for the local-bus strobe and status block.
// Assumes the reference clock runs at the rate named here.
`ifndef LBS_MAP_SVH
`define LBS_MAP_SVH
`define LBS_MCLK_PERIOD_NS   10
`define LBS_PROCESSOR_CLOCK_OUTPUT_PERIOD_NS 100
`define LBS_HALF_CYCLES      (`LBS_PROCESSOR_CLOCK_OUTPUT_PERIOD_NS / (2 * `LBS_MCLK_PERIOD_NS))
`define LBS_UBE_RESET        1'b1
`define LBS_WR_RESET         1'b1
`endif

// ### core/lbs_pkg.sv
// Types shared by the local-bus strobe and status block.
// Assumes nothing beyond the map header.
package lbs_pkg;
	typedef enum logic [2:0]
	{
		LBS_IDLE = 3'b000,
		LBS_T1   = 3'b001,
		LBS_T2   = 3'b010,
		LBS_T3   = 3'b011,
		LBS_TW   = 3'b100,
		LBS_T4   = 3'b101,
		LBS_HOLD = 3'b110
	} lbs_state_type;
	typedef enum logic [1:0]
	{
		LBS_CYC_READ  = 2'b00,
		LBS_CYC_WRITE = 2'b01,
		LBS_CYC_INTA  = 2'b10
	} lbs_cycle_type;
	typedef enum logic [1:0]
	{
		LBS_W_WORD  = 2'b00,
		LBS_W_UPPER = 2'b01,
		LBS_W_LOWER = 2'b10
	} lbs_width_type;
	// Queue codes as {queue_state_bit_high, queue_state_bit_low}
	typedef enum logic [1:0]
	{
		LBS_Q_NONE  = 2'b00,
		LBS_Q_FLUSH = 2'b01,
		LBS_Q_FIRST = 2'b10,
		LBS_Q_NEXT  = 2'b11
	} lbs_queue_type;
endpackage : lbs_pkg

// ### core/lbs_strobe.sv
// Local-bus strobe and status outputs: latch strobe, upper-byte enable/status, write strobe.
// Assumes synchronous inputs on mclk; a bus state spans one full period of the clock output.
// What this block does
// - In the first bus state the upper-byte enable is low when a byte moves on the upper data lines.
// - In bus states two to four the shared pin carries the status bit equal to the enable.
// - The shared upper-byte pin floats while the bus is held by another master.
// - The 8-bit variant keeps the upper-byte status high in normal operation.
// - The latch strobe is active high and the address is valid at its falling edge.
// - The latch strobe rises on the clock-output rising edge just before the first bus state.
// - The latch strobe falls on the clock-output rising edge inside the first bus state.
// - The latch strobe pin is always driven, even during hold.
// - The write strobe is active through bus states two, three and every wait state of a write.
// - The write strobe is active low and floats while the bus is held.
// - In queue status mode the latch and write strobe pins report queue activity.
// - Queue code zero-zero means no operation and one-one means a subsequent byte taken.
`timescale 1ns/10ps
`default_nettype none
`include "lbs_map.svh"
module lbs_strobe
	import lbs_pkg::*;
#(
	parameter int HALF_CYCLES = `LBS_HALF_CYCLES,
	parameter bit NARROW_BUS  = 1'b0
)
(
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          req_valid,
	input  wire lbs_cycle_type req_type,
	input  wire lbs_width_type req_width,
	input  wire logic          ready,
	input  wire logic          hold_req,
	input  wire logic          queue_mode,
	input  wire lbs_queue_type queue_op,
	output var  logic          req_taken,
	output var  logic          hold_ack,
	output var  logic          processor_clock_output,
	output var  logic          address_latch_strobe,
	output var  logic          upper_byte_enable,
	output var  logic          upper_byte_enable_oe,
	output var  logic          address_bit_zero,
	output var  logic          write_strobe,
	output var  logic          write_strobe_oe
);
	lbs_tick_if    dv ();
	lbs_state_type state;
	lbs_state_type next_state;
	lbs_cycle_type cur_type;
	lbs_width_type cur_width;
	logic          start_pending;
	logic          take;
	logic          fall;
	logic          in_data;

	lbs_clk_div #(.HALF_CYCLES(HALF_CYCLES)) u_div
	(
		.mclk (mclk),
		.rst  (rst),
		.dv   (dv)
	);

	// A request is only accepted where a new cycle can follow at the next state boundary
	assign take = dv.tick && dv.rise && (state == LBS_IDLE || state == LBS_T4)
		&& req_valid && !hold_req && !start_pending;
	assign fall = dv.tick && !dv.rise;
	assign in_data = (next_state == LBS_T2) || (next_state == LBS_T3) || (next_state == LBS_TW);

	always_comb
	begin
		next_state = state;
		unique case (state)
			LBS_IDLE, LBS_T4:
				if (start_pending)
					next_state = LBS_T1;
				else if (hold_req)
					next_state = LBS_HOLD;
				else
					next_state = LBS_IDLE;
			LBS_T1:
				next_state = LBS_T2;
			LBS_T2:
				next_state = LBS_T3;
			LBS_T3, LBS_TW:
				next_state = ready ? LBS_T4 : LBS_TW;
			LBS_HOLD:
				next_state = hold_req ? LBS_HOLD : LBS_IDLE;
			default:
				next_state = LBS_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			processor_clock_output <= 1'b0;
		else if (dv.tick)
			processor_clock_output <= dv.rise;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= LBS_IDLE;
			start_pending <= 1'b0;
			cur_type <= LBS_CYC_READ;
			cur_width <= LBS_W_WORD;
			req_taken <= 1'b0;
			hold_ack <= 1'b0;
		end
		else
		begin
			req_taken <= take;
			if (take)
			begin
				start_pending <= 1'b1;
				cur_type <= req_type;
				cur_width <= req_width;
			end
			if (fall)
			begin
				state <= next_state;
				hold_ack <= (next_state == LBS_HOLD);
				if (next_state == LBS_T1)
					start_pending <= 1'b0;
			end
		end
	end

	// Latch strobe never floats; in queue mode it carries the low queue bit
	always_ff @(posedge mclk)
	begin
		if (rst)
			address_latch_strobe <= 1'b0;
		else if (queue_mode)
		begin
			if (fall)
				address_latch_strobe <= queue_op[0];
		end
		else if (dv.tick && dv.rise && state == LBS_T1)
			address_latch_strobe <= 1'b0;
		else if (take)
			address_latch_strobe <= 1'b1;
		else if (!start_pending && state != LBS_T1)
			address_latch_strobe <= 1'b0;
		// Last branch drops a queue bit left high on leaving queue mode, so no stray latch pulse follows
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			write_strobe <= `LBS_WR_RESET;
			write_strobe_oe <= 1'b1;
		end
		else if (fall)
		begin
			write_strobe_oe <= (next_state != LBS_HOLD);
			if (queue_mode)
				write_strobe <= queue_op[1];
			else
				write_strobe <= !(in_data && cur_type == LBS_CYC_WRITE);
		end
	end

	// Enable is set at entry to the first state and simply held as status until the cycle ends
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			upper_byte_enable <= `LBS_UBE_RESET;
			upper_byte_enable_oe <= 1'b1;
			address_bit_zero <= 1'b0;
		end
		else if (fall)
		begin
			upper_byte_enable_oe <= (next_state != LBS_HOLD);
			if (NARROW_BUS)
				upper_byte_enable <= 1'b1;
			else if (next_state == LBS_T1)
				upper_byte_enable <= (cur_width == LBS_W_LOWER);
			if (next_state == LBS_T1)
				address_bit_zero <= (cur_width == LBS_W_UPPER);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	ale_fall_t1_a: assert property ($fell(address_latch_strobe) && !queue_mode && !$past(queue_mode, 2)
		|-> state == LBS_T1)
		else $error("latch strobe fell outside the first bus state");
	ale_rise_pre_a: assert property ($rose(address_latch_strobe) && !queue_mode
		|-> (state == LBS_IDLE || state == LBS_T4) && start_pending)
		else $error("latch strobe rose without a pending cycle");
	ale_t1_seen_a: assert property ($rose(state == LBS_T1) && !queue_mode |-> address_latch_strobe)
		else $error("latch strobe low at start of first state");
	ube_hold_float_a: assert property (state == LBS_HOLD |-> !upper_byte_enable_oe)
		else $error("upper-byte pin driven during hold");
	wr_hold_float_a: assert property (state == LBS_HOLD |-> !write_strobe_oe)
		else $error("write strobe driven during hold");
	wr_active_a: assert property ((state == LBS_T2 || state == LBS_T3 || state == LBS_TW)
		&& cur_type == LBS_CYC_WRITE && !queue_mode && $past(!queue_mode) |-> !write_strobe)
		else $error("write strobe inactive in a write data state");
	wr_quiet_a: assert property ((state == LBS_T1 || state == LBS_T4) && !queue_mode
		&& $past(!queue_mode) |-> write_strobe)
		else $error("write strobe active outside data states");
	ube_status_a: assert property (state == LBS_T2 && $past(state) == LBS_T1
		|-> upper_byte_enable == $past(upper_byte_enable))
		else $error("upper-byte status differs from enable");
	ube_narrow_a: assert property (NARROW_BUS && state != LBS_IDLE && state != LBS_HOLD |-> upper_byte_enable)
		else $error("upper-byte status low on narrow bus");
	ube_encode_a: assert property (state == LBS_T1 && !NARROW_BUS |-> !(upper_byte_enable && address_bit_zero))
		else $error("illegal enable and bit zero pair");
endmodule : lbs_strobe
`default_nettype wire

// ### core/lbs_tick_if.sv
// Half-period tick carrier between divider and strobe logic.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface lbs_tick_if;
	logic tick;
	logic rise;
	modport src (output tick, output rise);
	modport snk (input tick, input rise);
endinterface : lbs_tick_if
`default_nettype wire

// ### tb/lbs_far_side.sv
// Far-side model: address latch plus a memory that answers with ready.
// Assumes a clock-output half period of H mclk cycles.
`timescale 1ns/10ps
`default_nettype none
module lbs_far_side
#(
	parameter int H = 2
)
(
	input  wire logic mclk,
	input  wire logic ale,
	input  wire logic ube,
	input  wire logic ube_oe,
	input  wire logic bit0,
	input  wire logic wr,
	input  wire logic wr_oe,
	input  var  int   waits,
	output var  logic ready,
	output var  logic lat_bit0,
	output var  logic lat_ube,
	output var  int   ale_len,
	output var  int   wr_len
);
	logic ale_q = 1'b0;
	logic ube_last = 1'b1;
	int   cnt = 0;
	int   ale_run = 0;
	int   wr_run = 0;
	// A floated pin reads as the inverse of its last level, never a stale copy
	always @(posedge mclk)
	begin
		if (ube_oe)
			ube_last <= ube;
		ale_q <= ale;
		ale_run <= ale ? ale_run + 1 : 0;
		wr_run <= (wr_oe && !wr) ? wr_run + 1 : 0;
		cnt <= cnt + 1;
		if (ale_q && !ale)
		begin
			lat_bit0 <= bit0;
			lat_ube <= ube_oe ? ube : ~ube_last;
			ale_len <= ale_run;
			wr_len <= 0;
			cnt <= 1;
		end
		if (wr_run != 0 && !(wr_oe && !wr))
			wr_len <= wr_run;
		// Slow answer: ready only after the requested number of wait states
		ready <= cnt >= 4 * H + 2 * H * waits;
	end
endmodule : lbs_far_side
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the local-bus strobe block.
// Assumes the far-side model and a small half period for speed.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import lbs_pkg::*;
	localparam int H = 2;
	logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, hold_req = 1'b0, queue_mode = 1'b0;
	logic ready, req_taken, hold_ack, clk_out, ale, ube, ube_oe, bit0, wr, wr_oe, lat_bit0, lat_ube;
	lbs_cycle_type req_type = LBS_CYC_READ;
	lbs_width_type req_width = LBS_W_WORD;
	lbs_queue_type queue_op = LBS_Q_NONE;
	int waits = 0, ale_len, wr_len, error_cnt = 0, compares = 0, cyc = 0;
	lbs_strobe #(.HALF_CYCLES(H)) u_lbs_strobe (.mclk(mclk), .rst(rst), .req_valid(req_valid),
		.req_type(req_type), .req_width(req_width), .ready(ready), .hold_req(hold_req),
		.queue_mode(queue_mode), .queue_op(queue_op), .req_taken(req_taken), .hold_ack(hold_ack),
		.processor_clock_output(clk_out), .address_latch_strobe(ale), .upper_byte_enable(ube),
		.upper_byte_enable_oe(ube_oe), .address_bit_zero(bit0), .write_strobe(wr), .write_strobe_oe(wr_oe));
	lbs_far_side #(.H(H)) u_lbs_far_side (.mclk(mclk), .ale(ale), .ube(ube), .ube_oe(ube_oe), .bit0(bit0),
		.wr(wr), .wr_oe(wr_oe), .waits(waits), .ready(ready), .lat_bit0(lat_bit0), .lat_ube(lat_ube),
		.ale_len(ale_len), .wr_len(wr_len));
	initial
	begin
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("error_cnt=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t cycle ceiling reached", $time);
			close_out;
		end
	end
	task automatic t_reset;
		chk(16'({clk_out, ale, ube, wr, ube_oe, wr_oe, bit0, hold_ack, req_taken}), 16'h0078);
	endtask : t_reset
	task automatic t_cycle(input lbs_cycle_type ty, input lbs_width_type w, input int n, input logic eu,
		input logic ea);
		int i;
		logic bad;
		bad = 1'b0;
		i = 0;
		@(posedge mclk);
		waits <= n;
		req_type <= ty;
		req_width <= w;
		req_valid <= 1'b1;
		do @(posedge mclk); while (req_taken !== 1'b1 && ++i < 40);
		chk(16'({req_taken, ale, clk_out}), 16'h0007);
		req_valid <= 1'b0;
		for (i = 0; i < (4 + n) * 2 * H + H + 2; i++)
		begin
			@(posedge mclk);
			if (ty != LBS_CYC_WRITE && wr !== 1'b1)
				bad = 1'b1;
		end
		chk(16'(bad), 16'h0000);
		chk(16'(lat_ube), 16'(eu));
		chk(16'(ube), 16'(eu));
		chk(16'(lat_bit0), 16'(ea));
		chk(16'(ale_len), 16'(2 * H));
		chk(16'(wr_len), 16'(ty == LBS_CYC_WRITE ? (2 + n) * 2 * H : 0));
	endtask : t_cycle
	task automatic t_hold;
		int i;
		@(posedge mclk);
		hold_req <= 1'b1;
		for (i = 0; i < 20 && hold_ack !== 1'b1; i++) @(posedge mclk);
		chk(16'({hold_ack, ube_oe, wr_oe, ale}), 16'h0008);
		hold_req <= 1'b0;
		for (i = 0; i < 20 && hold_ack !== 1'b0; i++) @(posedge mclk);
		@(posedge mclk);
		chk(16'({hold_ack, ube_oe, wr_oe}), 16'h0003);
	endtask : t_hold
	task automatic t_queue;
		int c;
		@(posedge mclk);
		queue_mode <= 1'b1;
		for (c = 0; c < 4; c++)
		begin
			queue_op <= lbs_queue_type'(c);
			repeat (4 * H) @(posedge mclk);
			chk(16'({wr, ale}), 16'(c[1:0]));
		end
		queue_mode <= 1'b0;
		queue_op <= LBS_Q_NONE;
		repeat (4 * H) @(posedge mclk);
	endtask : t_queue
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset;
		t_cycle(LBS_CYC_WRITE, LBS_W_WORD, 0, 1'b0, 1'b0);
		t_cycle(LBS_CYC_WRITE, LBS_W_UPPER, 1, 1'b0, 1'b1);
		t_cycle(LBS_CYC_WRITE, LBS_W_LOWER, 2, 1'b1, 1'b0);
		t_cycle(LBS_CYC_READ, LBS_W_UPPER, 1, 1'b0, 1'b1);
		t_cycle(LBS_CYC_INTA, LBS_W_WORD, 0, 1'b0, 1'b0);
		t_hold;
		t_queue;
		// Mid-run reset: outputs must return to their idle levels before the next cycle
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset;
		t_cycle(LBS_CYC_WRITE, LBS_W_LOWER, 0, 1'b1, 1'b0);
		close_out;
	end
endmodule : testbench
`default_nettype wire
